/* File: travel_alert_monitor.sv */
// travel position and deviation alerts, cutoffs, target limits, watchdog
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - high alert when travel exceeds high point
// - high-high alert above its own point
// - low alert when travel below low point
// - low-low alert below its own point
// - active alert clears once travel is back past the point by the deadband (high alerts: point minus deadband)
// - deadband settable from -25 to 125 percent
// - deviation equals target minus ranged travel
// - deviation alert after excess outlasts deviation time
// - deviation alert clears once below point
// - deviation point 0 to 100 percent, typically 5
// - deviation time 1 to 60 seconds
// - beyond cutoff force drive maximum or minimum
// - no rate limiting while beyond a cutoff
// - target clamped between low and high limits
// - watchdog expiry resets, firmware must rearm
// - opening/closing times 0-400 s, zero disables
module travel_alert_monitor #(
	parameter int TICK_CYCLES = travel_alert_pkg::TICK_CYCLES,
	parameter int UNIT_CYCLES = travel_alert_pkg::UNIT_CYCLES,
	parameter int WDOG_CYCLES = travel_alert_pkg::WDOG_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// measured and requested travel
	input wire logic signed [travel_alert_pkg::PCT_W-1:0] travel,
	input wire logic signed [travel_alert_pkg::PCT_W-1:0] target_in,
	// position alert setup
	input wire logic signed [travel_alert_pkg::PCT_W-1:0] hi_point,
	input wire logic signed [travel_alert_pkg::PCT_W-1:0] hihi_point,
	input wire logic signed [travel_alert_pkg::PCT_W-1:0] lo_point,
	input wire logic signed [travel_alert_pkg::PCT_W-1:0] lolo_point,
	input wire logic signed [travel_alert_pkg::PCT_W-1:0] alert_deadband,
	// deviation setup
	input wire logic signed [travel_alert_pkg::PCT_W-1:0] dev_point,
	input wire logic [travel_alert_pkg::DEV_TIME_W-1:0] dev_time,
	// cutoffs, limits and rate limits
	input wire logic signed [travel_alert_pkg::PCT_W-1:0] cutoff_hi,
	input wire logic signed [travel_alert_pkg::PCT_W-1:0] cutoff_lo,
	input wire logic signed [travel_alert_pkg::PCT_W-1:0] limit_hi,
	input wire logic signed [travel_alert_pkg::PCT_W-1:0] limit_lo,
	input wire logic zero_sig_closed,
	input wire logic [travel_alert_pkg::MOVE_TIME_W-1:0] min_open_time,
	input wire logic [travel_alert_pkg::MOVE_TIME_W-1:0] min_close_time,
	// watchdog
	input wire logic wdog_rearm,
	// alerts
	output logic alert_hi,
	output logic alert_hihi,
	output logic alert_lo,
	output logic alert_lolo,
	output logic alert_dev,
	// control outputs
	output logic signed [travel_alert_pkg::PCT_W-1:0] target_out,
	output logic signed [travel_alert_pkg::EXT_W-1:0] deviation,
	output logic drive_max,
	output logic drive_min,
	output logic cutoff_active,
	output logic wdog_reset
);
	localparam int PW = travel_alert_pkg::PCT_W;
	localparam int EW = travel_alert_pkg::EXT_W;
	localparam int CW = travel_alert_pkg::CNT_W;
	localparam int DW = travel_alert_pkg::DEV_TIME_W;

	// bound a percent value into a window
	function automatic logic signed [PW-1:0] clamp_pct(input logic signed [PW-1:0] v,
		input logic signed [PW-1:0] lo, input logic signed [PW-1:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	// upper alert: set above point, hold until back by deadband
	function automatic logic above_alert(input logic act, input logic signed [PW-1:0] tr,
		input logic signed [PW-1:0] pt, input logic signed [PW-1:0] db);
		logic signed [EW-1:0] clr;
		clr = EW'(pt) - EW'(db);
		if (act) begin
			return EW'(tr) > clr;
		end
		return tr > pt;
	endfunction

	// lower alert: set below point, hold until back by deadband
	function automatic logic below_alert(input logic act, input logic signed [PW-1:0] tr,
		input logic signed [PW-1:0] pt, input logic signed [PW-1:0] db);
		logic signed [EW-1:0] clr;
		clr = EW'(pt) + EW'(db);
		if (act) begin
			return EW'(tr) < clr;
		end
		return tr < pt;
	endfunction

	logic rst;
	logic wdog_reset_reg, wdog_reset_next;
	logic [CW-1:0] wdog_cnt_reg, wdog_cnt_next;
	logic [CW-1:0] sec_cnt_reg, sec_cnt_next;
	logic tick;
	logic signed [PW-1:0] pt_hi, pt_hihi, pt_lo, pt_lolo, db, pt_dev;
	logic [travel_alert_pkg::DEV_TIME_W-1:0] dev_secs;
	logic hi_reg, hi_next, hihi_reg, hihi_next, lo_reg, lo_next, lolo_reg, lolo_next;
	logic signed [EW-1:0] dev_reg, dev_next, dev_abs;
	logic excess, at_or_below;
	logic [travel_alert_pkg::DEV_TIME_W-1:0] dev_cnt_reg, dev_cnt_next;
	logic dev_alert_reg, dev_alert_next;
	logic cut_hi, cut_lo;
	logic max_reg, max_next, min_reg, min_next, cut_reg, cut_next;
	logic signed [PW-1:0] goal, target_reg, target_next;
	logic [CW-1:0] rate_cnt_reg, rate_cnt_next, step_period;
	logic [travel_alert_pkg::MOVE_TIME_W-1:0] open_t, close_t;

	// watchdog expiry resets the rest of the instrument
	assign rst = sys_rst | wdog_reset_reg;

	// sanitised settings: percents on the common signed scale, times in whole seconds
	assign pt_hi = clamp_pct(hi_point, travel_alert_pkg::PCT_LOW,
		travel_alert_pkg::PCT_HIGH);
	assign pt_hihi = clamp_pct(hihi_point, travel_alert_pkg::PCT_LOW,
		travel_alert_pkg::PCT_HIGH);
	assign pt_lo = clamp_pct(lo_point, travel_alert_pkg::PCT_LOW,
		travel_alert_pkg::PCT_HIGH);
	assign pt_lolo = clamp_pct(lolo_point, travel_alert_pkg::PCT_LOW,
		travel_alert_pkg::PCT_HIGH);
	assign db = clamp_pct(alert_deadband, travel_alert_pkg::PCT_LOW,
		travel_alert_pkg::PCT_HIGH);
	assign pt_dev = clamp_pct(dev_point, travel_alert_pkg::DEV_PT_LOW,
		travel_alert_pkg::DEV_PT_HIGH);
	assign dev_secs = (dev_time < travel_alert_pkg::DEV_TIME_LOW) ?
		travel_alert_pkg::DEV_TIME_LOW : (dev_time > travel_alert_pkg::DEV_TIME_HIGH) ?
		travel_alert_pkg::DEV_TIME_HIGH : dev_time;
	assign open_t = (min_open_time > travel_alert_pkg::MOVE_TIME_HIGH) ?
		travel_alert_pkg::MOVE_TIME_HIGH : min_open_time;
	assign close_t = (min_close_time > travel_alert_pkg::MOVE_TIME_HIGH) ?
		travel_alert_pkg::MOVE_TIME_HIGH : min_close_time;

	// watchdog counter, rearmed by firmware
	always_comb begin
		wdog_cnt_next = wdog_cnt_reg + CW'(1);
		wdog_reset_next = 1'b0;
		if (wdog_rearm) begin
			wdog_cnt_next = '0;
		end else if (wdog_cnt_reg >= CW'(WDOG_CYCLES - 1)) begin
			wdog_cnt_next = '0;
			wdog_reset_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wdog_cnt_reg <= '0;
			wdog_reset_reg <= 1'b0;
		end else begin
			wdog_cnt_reg <= wdog_cnt_next;
			wdog_reset_reg <= wdog_reset_next;
		end
	end

	// one-second tick from the system clock
	assign tick = (sec_cnt_reg == CW'(TICK_CYCLES - 1));
	always_comb begin
		sec_cnt_next = tick ? '0 : sec_cnt_reg + CW'(1);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sec_cnt_reg <= '0;
		end else begin
			sec_cnt_reg <= sec_cnt_next;
		end
	end

	// position alerts with clearing deadband
	always_comb begin
		hi_next = above_alert(hi_reg, travel, pt_hi, db);
		hihi_next = above_alert(hihi_reg, travel, pt_hihi, db);
		lo_next = below_alert(lo_reg, travel, pt_lo, db);
		lolo_next = below_alert(lolo_reg, travel, pt_lolo, db);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hi_reg <= 1'b0;
			hihi_reg <= 1'b0;
			lo_reg <= 1'b0;
			lolo_reg <= 1'b0;
		end else begin
			hi_reg <= hi_next;
			hihi_reg <= hihi_next;
			lo_reg <= lo_next;
			lolo_reg <= lolo_next;
		end
	end

	// deviation persistence and alert
	assign dev_next = EW'(target_reg) - EW'(travel);
	assign dev_abs = dev_reg[EW-1] ? -dev_reg : dev_reg;
	assign excess = dev_abs > EW'(pt_dev);
	assign at_or_below = !excess;
	always_comb begin
		dev_cnt_next = dev_cnt_reg;
		dev_alert_next = dev_alert_reg;
		if (at_or_below) begin
			dev_cnt_next = '0;
		end else if (tick && dev_cnt_reg != travel_alert_pkg::DEV_CNT_TOP) begin
			dev_cnt_next = dev_cnt_reg + DW'(1);
		end
		if (excess && tick && dev_cnt_reg >= dev_secs) begin
			dev_alert_next = 1'b1;
		end else if (dev_abs < EW'(pt_dev)) begin
			dev_alert_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dev_reg <= '0;
			dev_cnt_reg <= '0;
			dev_alert_reg <= 1'b0;
		end else begin
			dev_reg <= dev_next;
			dev_cnt_reg <= dev_cnt_next;
			dev_alert_reg <= dev_alert_next;
		end
	end

	// travel cutoffs force the drive to an extreme
	assign cut_hi = travel > cutoff_hi;
	assign cut_lo = travel < cutoff_lo;
	always_comb begin
		cut_next = cut_hi | cut_lo;
		max_next = (cut_hi & zero_sig_closed) | (cut_lo & !zero_sig_closed);
		min_next = (cut_hi & !zero_sig_closed) | (cut_lo & zero_sig_closed);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cut_reg <= 1'b0;
			max_reg <= 1'b0;
			min_reg <= 1'b0;
		end else begin
			cut_reg <= cut_next;
			max_reg <= max_next;
			min_reg <= min_next;
		end
	end

	// target limiting and rate limiting, one count per step period
	assign goal = clamp_pct(target_in, limit_lo, limit_hi);
	assign step_period = (goal > target_reg) ? CW'(open_t) * CW'(UNIT_CYCLES) :
		CW'(close_t) * CW'(UNIT_CYCLES);
	always_comb begin
		target_next = target_reg;
		rate_cnt_next = '0;
		if (goal == target_reg) begin
			target_next = goal;
		end else if (cut_reg || step_period == '0) begin
			target_next = goal;
		end else if (rate_cnt_reg >= step_period - CW'(1)) begin
			target_next = (goal > target_reg) ? target_reg + PW'(1) : target_reg - PW'(1);
		end else begin
			rate_cnt_next = rate_cnt_reg + CW'(1);
		end
		target_next = clamp_pct(target_next, limit_lo, limit_hi);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			target_reg <= travel_alert_pkg::TARGET_RST;
			rate_cnt_reg <= '0;
		end else begin
			target_reg <= target_next;
			rate_cnt_reg <= rate_cnt_next;
		end
	end

	// outputs from registers
	assign alert_hi = hi_reg;
	assign alert_hihi = hihi_reg;
	assign alert_lo = lo_reg;
	assign alert_lolo = lolo_reg;
	assign alert_dev = dev_alert_reg;
	assign target_out = target_reg;
	assign deviation = dev_reg;
	assign drive_max = max_reg;
	assign drive_min = min_reg;
	assign cutoff_active = cut_reg;
	assign wdog_reset = wdog_reset_reg;
endmodule

`default_nettype wire

/* File: travel_alert_pkg.sv */
// shared constants for the travel alert monitor
`default_nettype none
package travel_alert_pkg;
	// percent scale: signed hundredths of a percent of ranged travel
	localparam int PCT_W = 16;
	localparam int EXT_W = 18;
	localparam logic signed [PCT_W-1:0] PCT_LOW = -16'sh09C4; // -25 percent
	localparam logic signed [PCT_W-1:0] PCT_HIGH = 16'sh30D4; // 125 percent
	localparam logic signed [PCT_W-1:0] DEV_PT_LOW = 16'sh0000; // 0 percent
	localparam logic signed [PCT_W-1:0] DEV_PT_HIGH = 16'sh2710; // 100 percent
	localparam logic signed [PCT_W-1:0] DEV_PT_TYPICAL = 16'sh01F4; // 5 percent
	localparam logic signed [PCT_W-1:0] TARGET_RST = 16'sh0000;
	localparam int FULL_SCALE = 10000; // counts in one full-range move

	// deviation time in whole seconds
	localparam int DEV_TIME_W = 6;
	localparam logic [DEV_TIME_W-1:0] DEV_TIME_LOW = 6'h01;
	localparam logic [DEV_TIME_W-1:0] DEV_TIME_HIGH = 6'h3C;
	localparam logic [DEV_TIME_W-1:0] DEV_CNT_TOP = 6'h3F;

	// minimum opening and closing time in seconds
	localparam int MOVE_TIME_W = 9;
	localparam logic [MOVE_TIME_W-1:0] MOVE_TIME_HIGH = 9'h190; // 400 s
	localparam logic [MOVE_TIME_W-1:0] MOVE_TIME_OFF = 9'h000;

	// timing, derived from the 50 ns clock period
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_PERIOD_S = 1;
	localparam int TICK_CYCLES = TICK_PERIOD_S * 1000000000 / CLK_PERIOD_NS;
	localparam int UNIT_CYCLES = TICK_CYCLES / FULL_SCALE;
	localparam int WDOG_TIMEOUT_MS = 100;
	localparam int WDOG_CYCLES = WDOG_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CNT_W = 32;
endpackage
`default_nettype wire

/* File: travel_alert_monitor_chk.sv */
// concurrent checks on the travel alert monitor ports
`timescale 1ns/100ps
`default_nettype none
module travel_alert_monitor_chk #(
	parameter int TICK_CYCLES = 20,
	parameter int UNIT_CYCLES = 2,
	parameter int WDOG_CYCLES = 50
) (
	// clock, reset and setup inputs
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic signed [15:0] travel,
	input wire logic signed [15:0] hi_point,
	input wire logic signed [15:0] lo_point,
	input wire logic signed [15:0] alert_deadband,
	input wire logic signed [15:0] dev_point,
	input wire logic [5:0] dev_time,
	input wire logic signed [15:0] cutoff_hi,
	input wire logic zero_sig_closed,
	input wire logic wdog_rearm,
	// watched outputs
	input wire logic alert_hi,
	input wire logic alert_lo,
	input wire logic alert_dev,
	input wire logic signed [17:0] deviation,
	input wire logic drive_max,
	input wire logic cutoff_active,
	input wire logic wdog_reset
);
	int ex_cnt;
	int idle_cnt;
	logic rst_d = 1'b1;
	logic excess;
	assign excess = (deviation > dev_point) || (deviation < -dev_point);
	// cycles of unbroken excess and of missing rearm
	always_ff @(posedge clk) begin
		ex_cnt <= (sys_rst || wdog_reset || !excess) ? 0 : ex_cnt + 1;
		idle_cnt <= (sys_rst || wdog_rearm || wdog_reset) ? 0 : idle_cnt + 1;
		rst_d <= sys_rst || wdog_reset; // state is cleared one edge after the pulse
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst || wdog_reset || rst_d);
	sequence s_quiet; !alert_hi && !alert_lo && !alert_dev; endsequence
	property p_hi_set; travel > hi_point |=> alert_hi; endproperty
	a_hi_set: assert property (p_hi_set) else $error("high alert not set");
	property p_hi_hold; alert_hi && travel > hi_point - alert_deadband |=> alert_hi; endproperty
	a_hi_hold: assert property (p_hi_hold) else $error("high alert dropped early");
	property p_lo_set; travel < lo_point |=> alert_lo; endproperty
	a_lo_set: assert property (p_lo_set) else $error("low alert not set");
	property p_dev_rise; $rose(alert_dev) |-> ex_cnt >= dev_time * TICK_CYCLES - 2; endproperty
	a_dev_rise: assert property (p_dev_rise) else $error("deviation alert too soon");
	property p_dev_clear; deviation < dev_point && deviation > -dev_point |=> !alert_dev;
	endproperty
	a_dev_clear: assert property (p_dev_clear) else $error("deviation alert stuck");
	property p_cut_max; travel > cutoff_hi && zero_sig_closed |=> drive_max && cutoff_active;
	endproperty
	a_cut_max: assert property (p_cut_max) else $error("cutoff drive missing");
	property p_wd_early; disable iff (sys_rst) wdog_reset |-> idle_cnt >= WDOG_CYCLES - 1;
	endproperty
	a_wd_early: assert property (p_wd_early) else $error("watchdog fired early");
	property p_wd_late; disable iff (sys_rst) idle_cnt <= WDOG_CYCLES + 1; endproperty
	a_wd_late: assert property (p_wd_late) else $error("watchdog never fired");
	property p_wd_clr; disable iff (sys_rst) wdog_reset |=> s_quiet; endproperty
	a_wd_clr: assert property (p_wd_clr) else $error("alerts survive watchdog");
endmodule
bind travel_alert_monitor travel_alert_monitor_chk #(.TICK_CYCLES(TICK_CYCLES),
	.UNIT_CYCLES(UNIT_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) u_chk (.clk, .sys_rst, .travel,
	.hi_point, .lo_point, .alert_deadband, .dev_point, .dev_time, .cutoff_hi, .zero_sig_closed,
	.wdog_rearm, .alert_hi, .alert_lo, .alert_dev, .deviation, .drive_max, .cutoff_active,
	.wdog_reset);
`default_nettype wire

/* File: travel_sensor_model.sv */
// stand-in travel sensor: reports the commanded stem position one clock late
`timescale 1ns/100ps
`default_nettype none
module travel_sensor_model (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// commanded stem and sensed travel
	input wire logic signed [15:0] pos_cmd,
	output logic signed [15:0] travel
);
	// saturates at the sensor span; toggles a pattern while held in reset
	always_ff @(posedge clk) begin
		if (sys_rst)
			travel <= (travel === 16'sh5A5A) ? 16'shA5A5 : 16'sh5A5A;
		else if (pos_cmd > travel_alert_pkg::PCT_HIGH)
			travel <= travel_alert_pkg::PCT_HIGH;
		else
			travel <= (pos_cmd < travel_alert_pkg::PCT_LOW) ? travel_alert_pkg::PCT_LOW : pos_cmd;
	end
endmodule
`default_nettype wire

/* File: test_travel_alert_monitor.sv */
// self-checking bench for the travel alert monitor
`timescale 1ns/100ps
`default_nettype none
module test_travel_alert_monitor;
	localparam int TK = 20;
	localparam int WD = 50;
	logic clk, sys_rst = 1'b1, zero_sig_closed = 1'b0, wdog_rearm = 1'b1;
	logic signed [15:0] pos_cmd = 16'sh1388, target_in = 16'sh1388, hi_point = 16'sh1F40;
	logic signed [15:0] hihi_point = 16'sh2328, lo_point = 16'sh07D0, lolo_point = 16'sh03E8;
	logic signed [15:0] alert_deadband = 16'sh01F4, dev_point = 16'sh2710, cutoff_hi = 16'sh2648;
	logic signed [15:0] cutoff_lo = 16'sh00C8, limit_hi = 16'sh2710, limit_lo = 16'sh0000;
	logic signed [15:0] travel, target_out, win_lo = 16'sh1B69, win_hi = 16'sh1B6F;
	logic [8:0] min_open_time = 9'h000, min_close_time = 9'h000;
	logic [5:0] dev_time = 6'h02;
	logic signed [17:0] deviation;
	logic alert_hi, alert_hihi, alert_lo, alert_lolo, alert_dev, drive_max, drive_min;
	logic cutoff_active, wdog_reset;
	logic [3:0] st = 4'h0;
	logic [31:0] exp_q[$], wd_n;
	int sel_q[$], pt[4] = '{8000, 9000, 2000, 1000};
	int tv[10] = '{5000, 8000, 8500, 7600, 7500, 9500, 1500, 2400, 500, 5000};
	int n_mismatch = 0, total_checks = 0, cyc = 0, v;
	integer seed = 32'hE173B338;
	event chk_ev;
	travel_alert_monitor #(.TICK_CYCLES(TK), .UNIT_CYCLES(2), .WDOG_CYCLES(WD)) DUT (.clk, .sys_rst,
		.travel, .target_in, .hi_point, .hihi_point, .lo_point, .lolo_point, .alert_deadband,
		.dev_point, .dev_time, .cutoff_hi, .cutoff_lo, .limit_hi, .limit_lo, .zero_sig_closed,
		.min_open_time, .min_close_time, .wdog_rearm, .alert_hi, .alert_hihi, .alert_lo,
		.alert_lolo, .alert_dev, .target_out, .deviation, .drive_max, .drive_min, .cutoff_active,
		.wdog_reset);
	travel_sensor_model u_model (.clk, .sys_rst, .pos_cmd, .travel);
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask
	function automatic logic [31:0] observe(input int s);
		case (s)
			0: return {alert_hi, alert_hihi, alert_lo, alert_lolo, alert_dev};
			1: return 32'(target_out);
			2: return {drive_max, drive_min, cutoff_active};
			4: return 32'(deviation);
			5: return {31'h0, target_out >= win_lo && target_out <= win_hi};
			default: return wd_n;
		endcase
	endfunction
	// note an expectation, then let the watcher compare once outputs settle
	task automatic expect_val(input int s, input logic [31:0] val);
		sel_q.push_back(s);
		exp_q.push_back(val);
		#1 -> chk_ev;
		#1;
	endtask
	task automatic go(input int n);
		repeat (n) @(posedge clk);
	endtask
	// step the stem and predict the four position alerts
	task automatic pos_step(input int t);
		@(posedge clk) pos_cmd <= 16'(t);
		go(2);
		for (int k = 0; k < 4; k++) st[3-k] = (k < 2) ? (t > pt[k] || (st[3-k] && t > pt[k] - 500))
			: (t < pt[k] || (st[3-k] && t < pt[k] + 500));
		expect_val(0, {27'h0, st, 1'b0});
	endtask
	task automatic dev_run(input logic signed [15:0] p, input int n, input logic a);
		@(posedge clk) pos_cmd <= p;
		go(n);
		expect_val(0, {31'h0, a});
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// watcher: oldest note against the current outputs
	always @(chk_ev) check(observe(sel_q.pop_front()), exp_q.pop_front());
	// cycle ceiling against hangs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		go(8);
		sys_rst <= 1'b0;
		foreach (tv[j]) pos_step(tv[j]);
		// excess, restart, excess long enough, recovery
		@(posedge clk) dev_point <= travel_alert_pkg::DEV_PT_TYPICAL;
		dev_run(16'sh16A8, 30, 1'b0);
		dev_run(16'sh1388, 5, 1'b0);
		dev_run(16'sh16A8, 30, 1'b0);
		dev_run(16'sh16A8, 42, 1'b1);
		expect_val(4, -32'sd800);
		dev_run(16'sh13EC, 3, 1'b0);
		@(posedge clk) dev_point <= 16'sh2710;
		for (v = 0; v < 4; v++) begin
			@(posedge clk) zero_sig_closed <= v[0];
			pos_cmd <= v[1] ? 16'sh26AC : 16'sh0064;
			go(2);
			expect_val(2, {29'h0, v[1] == v[0], v[1] != v[0], 1'b1});
		end
		@(posedge clk) min_open_time <= 9'h190;
		min_close_time <= 9'h190;
		target_in <= 16'sh1B58;
		go(2);
		expect_val(1, 32'sd7000);
		@(posedge clk) pos_cmd <= 16'sh1388;
		min_open_time <= 9'h001;
		min_close_time <= 9'h000;
		go(3);
		target_in <= 16'sh2710;
		go(40);
		expect_val(5, 32'h1);
		@(posedge clk) target_in <= 16'sh0BB8;
		go(2);
		expect_val(1, 32'sd3000);
		@(posedge clk) min_open_time <= 9'h000;
		limit_lo <= 16'sh0BB8;
		limit_hi <= 16'sh1B58;
		repeat (8) begin
			v = $random(seed) % 7500 + 5000;
			@(posedge clk) target_in <= 16'(v);
			go(1);
			expect_val(1, v < 3000 ? 3000 : v > 7000 ? 7000 : v);
		end
		@(posedge clk) pos_cmd <= 16'sh251C;
		wdog_rearm <= 1'b0;
		wd_n = 0;
		do begin
			@(posedge clk);
			#1 wd_n++;
		end while (wdog_reset !== 1'b1 && wd_n < 2 * WD);
		expect_val(6, WD);
		@(posedge clk) wdog_rearm <= 1'b1;
		expect_val(0, 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
